// File: src/ssc_defs.svh
`ifndef SSC_DEFS_SVH
`define SSC_DEFS_SVH
// Conversion clock numbering inside one cycle
`define SSC_CYC_W 4
`define SSC_CYC_FIRST 4'h1
`define SSC_CYC_CAL_LAST 4'h2
`define SSC_CYC_SAMPLE 4'h3
`define SSC_CYC_BIT_FIRST 4'h4
`define SSC_CYC_BIT_LAST 4'hd
`define SSC_CYC_LAST 4'he
// Result layout
`define SSC_RES_W 10
`define SSC_IDX_MSB 4'h9
`define SSC_TRIAL_INIT 10'h200
`define SSC_RES_RESET 10'h000
`endif

// File: src/ssc_pkg.sv
`include "ssc_defs.svh"
package ssc_pkg;
    // Sequencer phase
    typedef enum logic [0:0] {
        SSC_IDLE,
        SSC_RUN
    } ssc_state_t;

    // Whole state of the sequencer
    typedef struct packed {
        logic clk_s1;                      // Conversion clock sync stage 1
        logic clk_s2;                      // Conversion clock sync stage 2
        logic clk_q;                       // Previous synced clock, for edges
        logic sc_s1;                       // Start sync stage 1
        logic sc_s2;                       // Start sync stage 2
        logic cmp_s1;                      // Comparator sync stage 1
        logic cmp_s2;                      // Comparator sync stage 2
        ssc_state_t state;                 // Idle or converting
        logic [`SSC_CYC_W-1:0] cycle;      // Current conversion clock 1..14
        logic dout;                        // Serial data level
        logic dout_oe;                     // Serial data driven
        logic cal_en;                      // Offset calibration active
        logic track_en;                    // Track-and-hold tracking
        logic sample_hold;                 // One-cycle hold strobe
        logic last_step;                   // LSB decided last cycle
        logic result_valid;                // One-cycle result strobe
    } ssc_top_st_t;

    // Whole state of the approximation register
    typedef struct packed {
        logic [`SSC_RES_W-1:0] trial;      // Code presented to the DAC
        logic [`SSC_RES_W-1:0] result;     // Decided bits
    } ssc_sar_st_t;
endpackage : ssc_pkg

// File: src/ssc_sar_if.sv
`include "ssc_defs.svh"
interface ssc_sar_if;
    logic load;                            // Start a new approximation
    logic step;                            // Decide one bit
    logic comp;                            // Comparator: input above trial
    logic [`SSC_CYC_W-1:0] idx;            // Bit being decided
    logic [`SSC_RES_W-1:0] trial;          // Trial code
    logic [`SSC_RES_W-1:0] result;         // Finished result
    modport ctl (output load, output step, output comp, output idx, input trial, input result);
    modport sar (input load, input step, input comp, input idx, output trial, output result);
endinterface : ssc_sar_if

// File: src/ssc_sar.sv
`include "ssc_defs.svh"
module ssc_sar (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Sequencer side
    ssc_sar_if.sar bus
);
    ssc_pkg::ssc_sar_st_t s;
    ssc_pkg::ssc_sar_st_t next_s;

    // Binary search, one bit per step, MSB first
    always_comb begin
        next_s = s;
        if (bus.load) begin
            next_s.trial = `SSC_TRIAL_INIT;
            next_s.result = `SSC_RES_RESET;
        end else if (bus.step) begin
            // Straight binary: keep the bit when input is above it
            next_s.trial[bus.idx] = bus.comp;
            next_s.result[bus.idx] = bus.comp;
            if (bus.idx != 4'h0) begin
                next_s.trial[bus.idx - 4'h1] = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '{trial: `SSC_TRIAL_INIT, result: `SSC_RES_RESET};
        end else begin
            s <= next_s;
        end
    end

    assign bus.trial = s.trial;
    assign bus.result = s.result;

    load_msb_a: assert property (@(posedge clk) disable iff (rst) bus.load |=> s.trial == `SSC_TRIAL_INIT)
        else $error("trial code not at midscale after load");
    decide_bit_a: assert property (@(posedge clk) disable iff (rst)
        bus.step && !bus.load |=> s.result[$past(bus.idx)] == $past(bus.comp))
        else $error("decided bit differs from comparator");
endmodule : ssc_sar

// File: src/ssc_top.sv
`include "ssc_defs.svh"
module ssc_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Host pins
    input wire logic conv_clk,
    input wire logic start_convert_n,
    output logic dout,
    output logic dout_oe,
    // Analog core
    input wire logic comp_in,
    output logic cal_en,
    output logic track_en,
    output logic sample_hold,
    output logic [`SSC_RES_W-1:0] trial_code,
    // Parallel result
    output logic [`SSC_RES_W-1:0] result_bits,
    output logic result_valid
);
    ssc_pkg::ssc_top_st_t s;
    ssc_pkg::ssc_top_st_t next_s;
    ssc_sar_if sar_bus ();
    logic rise;
    logic fall;

    // True in the clocks that put out a result bit
    function automatic logic is_bit_cycle(input logic [`SSC_CYC_W-1:0] c);
        is_bit_cycle = (c >= `SSC_CYC_BIT_FIRST) && (c <= `SSC_CYC_BIT_LAST);
    endfunction : is_bit_cycle

    ssc_sar ssc_sar_i (
        .clk(clk),
        .rst(rst),
        .bus(sar_bus)
    );

    // Edges of the synced host clock; stage 1 is read only by stage 2
    assign rise = s.clk_s2 && !s.clk_q;
    assign fall = !s.clk_s2 && s.clk_q;

    // Load lands on the falling edge of clock 3, approximation steps on falling edges of clocks 4..13
    assign sar_bus.load = fall && (s.state == ssc_pkg::SSC_RUN) && (s.cycle == `SSC_CYC_SAMPLE);
    assign sar_bus.step = fall && (s.state == ssc_pkg::SSC_RUN) && is_bit_cycle(s.cycle);
    assign sar_bus.idx = 4'(`SSC_CYC_BIT_LAST - s.cycle);
    assign sar_bus.comp = s.cmp_s2;

    // Sequencer
    always_comb begin
        next_s = s;
        next_s.clk_s1 = conv_clk;
        next_s.clk_s2 = s.clk_s1;
        next_s.clk_q = s.clk_s2;
        next_s.sc_s1 = start_convert_n;
        next_s.sc_s2 = s.sc_s1;
        next_s.cmp_s1 = comp_in;
        next_s.cmp_s2 = s.cmp_s1;
        next_s.sample_hold = 1'b0;
        next_s.last_step = 1'b0;
        next_s.result_valid = s.last_step;
        case (s.state)
            ssc_pkg::SSC_IDLE: begin
                // Output floats; input keeps tracking while waiting
                next_s.dout_oe = 1'b0;
                next_s.track_en = 1'b1;
                if (rise && !s.sc_s2) begin
                    next_s.state = ssc_pkg::SSC_RUN;
                    next_s.cycle = `SSC_CYC_FIRST;
                    next_s.dout_oe = 1'b1;
                    next_s.dout = 1'b0;
                    next_s.cal_en = 1'b1;
                end
            end
            ssc_pkg::SSC_RUN: begin
                if (rise) begin
                    if (s.cycle == `SSC_CYC_LAST) begin
                        // Chained conversion, no idle clock between
                        next_s.cycle = `SSC_CYC_FIRST;
                        next_s.cal_en = 1'b1;
                        next_s.dout = 1'b0;
                    end else begin
                        next_s.cycle = 4'(s.cycle + 4'h1);
                    end
                    if (s.cycle == `SSC_CYC_BIT_LAST) begin
                        // Ready for next conversion: LSB ends here
                        next_s.dout = 1'b0;
                        next_s.track_en = 1'b1;
                    end
                end else if (fall) begin
                    if (s.cycle == `SSC_CYC_CAL_LAST) begin
                        next_s.cal_en = 1'b0;
                    end
                    if (s.cycle == `SSC_CYC_SAMPLE) begin
                        next_s.track_en = 1'b0;
                        next_s.sample_hold = 1'b1;
                    end
                    if (is_bit_cycle(s.cycle)) begin
                        // Bit changes just after the falling edge
                        next_s.dout = s.cmp_s2;
                        next_s.last_step = (s.cycle == `SSC_CYC_BIT_LAST);
                    end
                    if (s.cycle == `SSC_CYC_LAST) begin
                        if (s.sc_s2) begin
                            next_s.state = ssc_pkg::SSC_IDLE;
                            next_s.dout_oe = 1'b0;
                            next_s.dout = 1'b0;
                        end else begin
                            next_s.dout = 1'b0;
                        end
                    end
                end
            end
            default: begin
                next_s.state = ssc_pkg::SSC_IDLE;
                next_s.dout_oe = 1'b0;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from flip-flops
    assign dout = s.dout;
    assign dout_oe = s.dout_oe;
    assign cal_en = s.cal_en;
    assign track_en = s.track_en;
    assign sample_hold = s.sample_hold;
    assign result_valid = s.result_valid;
    assign trial_code = sar_bus.trial;
    assign result_bits = sar_bus.result;

    // All checks sample on the system clock, off in reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    cycle_range_a: assert property ((s.state == ssc_pkg::SSC_RUN) |->
        (s.cycle >= `SSC_CYC_FIRST) && (s.cycle <= `SSC_CYC_LAST))
        else $error("cycle count out of range");
    idle_start_a: assert property ((s.state == ssc_pkg::SSC_IDLE) && rise && !s.sc_s2 |=>
        (s.state == ssc_pkg::SSC_RUN) && (s.cycle == `SSC_CYC_FIRST) && s.dout_oe)
        else $error("conversion did not start on rising edge");
    early_low_a: assert property ((s.state == ssc_pkg::SSC_RUN) && (s.cycle <= `SSC_CYC_SAMPLE) |->
        s.dout_oe && !s.dout)
        else $error("output not low before MSB");
    cal_window_a: assert property (s.cal_en && (s.state == ssc_pkg::SSC_RUN) |->
        s.cycle <= `SSC_CYC_CAL_LAST)
        else $error("calibration outside clocks one and two");
    hold_edge_a: assert property (s.sample_hold |-> (s.cycle == `SSC_CYC_SAMPLE) && !s.track_en
        && $past(s.clk_q) && !$past(s.clk_s2))
        else $error("hold strobe not on fall of clock three");
    bit_out_a: assert property (fall && (s.state == ssc_pkg::SSC_RUN) && is_bit_cycle(s.cycle) |=>
        s.dout == $past(s.cmp_s2) && s.dout_oe)
        else $error("serial bit not the decided bit");
    lsb_cut_a: assert property (rise && (s.state == ssc_pkg::SSC_RUN)
        && (s.cycle == `SSC_CYC_BIT_LAST) |=> !s.dout && (s.cycle == `SSC_CYC_LAST))
        else $error("LSB not ended at clock fourteen");
    single_shot_a: assert property (fall && (s.state == ssc_pkg::SSC_RUN)
        && (s.cycle == `SSC_CYC_LAST) && s.sc_s2 |=> (s.state == ssc_pkg::SSC_IDLE) && !s.dout_oe)
        else $error("single shot did not release output");
    chain_low_a: assert property (fall && (s.state == ssc_pkg::SSC_RUN)
        && (s.cycle == `SSC_CYC_LAST) && !s.sc_s2 |=> s.dout_oe && !s.dout)
        else $error("chained conversion output not low");
    no_gap_a: assert property (rise && (s.state == ssc_pkg::SSC_RUN) && (s.cycle == `SSC_CYC_LAST) |=>
        (s.state == ssc_pkg::SSC_RUN) && (s.cycle == `SSC_CYC_FIRST))
        else $error("gap between chained conversions");
    // Start from idle: calibrate, track, output low
    cal_start_a: assert property ((s.state == ssc_pkg::SSC_IDLE) && rise && !s.sc_s2 |=>
        s.cal_en && s.track_en && !s.dout)
        else $error("start did not open calibration");
    // Calibration ends at the fall of clock two
    cal_stop_a: assert property (fall && (s.state == ssc_pkg::SSC_RUN)
        && (s.cycle == `SSC_CYC_CAL_LAST) |=> !s.cal_en)
        else $error("calibration ran past clock two");
    // Tracking resumes when the LSB is cut
    lsb_track_a: assert property (rise && (s.state == ssc_pkg::SSC_RUN)
        && (s.cycle == `SSC_CYC_BIT_LAST) |=> s.track_en)
        else $error("tracking not resumed at clock fourteen");
    // Chained start recalibrates with output driven low
    chain_cal_a: assert property (rise && (s.state == ssc_pkg::SSC_RUN)
        && (s.cycle == `SSC_CYC_LAST) |=> s.cal_en && !s.dout && s.dout_oe)
        else $error("chained start not calibrating");
    // Pin stays driven for the whole conversion
    run_driven_a: assert property ((s.state == ssc_pkg::SSC_RUN) |-> s.dout_oe)
        else $error("output released during conversion");
    // Idle: pin released unless a start is taken this cycle
    idle_float_a: assert property ((s.state == ssc_pkg::SSC_IDLE) && !(rise && !s.sc_s2) |=>
        !s.dout_oe)
        else $error("output driven while idle");
    // A start needs a detected rising edge
    idle_wait_a: assert property ((s.state == ssc_pkg::SSC_IDLE) && !rise |=>
        s.state == ssc_pkg::SSC_IDLE)
        else $error("conversion started without rising edge");
    // Input keeps tracking while nothing converts
    idle_track_a: assert property ((s.state == ssc_pkg::SSC_IDLE) |=> s.track_en)
        else $error("input not tracked while idle");
    // Hold strobe lasts one cycle only
    hold_pulse_a: assert property (s.sample_hold |=> !s.sample_hold)
        else $error("hold strobe longer than one cycle");
    // Bits move only at host clock edges inside the bit window
    bit_steady_a: assert property ((s.state == ssc_pkg::SSC_RUN) && is_bit_cycle(s.cycle)
        && !fall && !rise |=> $stable(s.dout))
        else $error("serial bit changed between falling edges");
    // Result strobe follows the LSB decision
    done_pulse_a: assert property (s.last_step |=> s.result_valid && !s.last_step)
        else $error("result strobe not after LSB decision");

    // Main scenarios reached
    single_cov: cover property (fall && (s.cycle == `SSC_CYC_LAST) && s.sc_s2
        && (s.state == ssc_pkg::SSC_RUN));
    chain_cov: cover property (rise && (s.cycle == `SSC_CYC_LAST) && (s.state == ssc_pkg::SSC_RUN));
    result_cov: cover property (s.result_valid);
    // Start found low at the fall of clock fourteen
    sync_cov: cover property (fall && (s.cycle == `SSC_CYC_LAST) && !s.sc_s2 && (s.state == ssc_pkg::SSC_RUN));
endmodule : ssc_top

// File: testbench/ssc_host.sv
// Host port plus analog source facing the sequencer pins
module ssc_host #(
    parameter int HALF = 10 // System clocks per conversion clock phase
) (
    // System side
    input wire logic clk,
    input wire logic rst,
    // Test control
    input wire logic run,
    input wire logic sc_req_n,
    input wire logic [10:0] vin2,
    // Device pins
    input wire logic [9:0] trial_code,
    output logic conv_clk,
    output logic start_convert_n,
    output logic comp_in
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt; // Phase counter

    // Even duty clock, parked low between frames, never cut mid-phase
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt <= 0;
            conv_clk <= 1'b0;
            start_convert_n <= 1'b1;
        end else begin
            start_convert_n <= sc_req_n;
            if (run || conv_clk) begin
                if (cnt == HALF - 1) begin
                    cnt <= 0;
                    conv_clk <= !conv_clk;
                end else begin
                    cnt <= cnt + 1;
                end
            end else begin
                cnt <= 0;
            end
        end
    end

    // Input held in half steps, so no trial code ever ties with it
    assign comp_in = vin2 > {trial_code, 1'b0};
endmodule : ssc_host

// File: testbench/tb_serial_sar_conversion_sequencer.sv
module tb_serial_sar_conversion_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0; // System clock
    logic rst = 1'b1; // Synchronous reset
    logic run = 1'b0; // Host clock enable
    logic sc_req_n = 1'b1; // Requested start level
    logic [10:0] vin2 = 11'h001; // Analog input, half steps
    logic conv_clk, start_convert_n, comp_in, dout, dout_oe;
    logic cal_en, track_en, sample_hold, result_valid;
    logic [9:0] trial_code, result_bits;
    int error_cnt = 0;
    int num_checks = 0;
    int hold_cnt = 0; // Hold strobes seen
    int done_cnt = 0; // Result strobes seen

    // 100 MHz clock
    always #5 clk = !clk;

    // Count the one-cycle strobes so each frame can judge them
    always @(posedge clk) begin
        if (sample_hold === 1'b1)
            hold_cnt <= hold_cnt + 1;
        if (result_valid === 1'b1)
            done_cnt <= done_cnt + 1;
    end

    ssc_host ssc_host_i (.clk(clk), .rst(rst), .run(run), .sc_req_n(sc_req_n), .vin2(vin2),
        .trial_code(trial_code), .conv_clk(conv_clk), .start_convert_n(start_convert_n), .comp_in(comp_in));
    ssc_top ssc_top_i (.clk(clk), .rst(rst), .conv_clk(conv_clk), .start_convert_n(start_convert_n),
        .dout(dout), .dout_oe(dout_oe), .comp_in(comp_in), .cal_en(cal_en), .track_en(track_en),
        .sample_hold(sample_hold), .trial_code(trial_code), .result_bits(result_bits),
        .result_valid(result_valid));

    // One comparison, counted
    task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Counts and verdict
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict

    // One 14-clock frame; bits sampled at the next rise, the LSB at rise 14 before it drops
    task automatic frame(input logic [9:0] code, input logic keep_low, input logic relow);
        logic [9:0] bits;
        int hold0;
        int done0;
        hold0 = hold_cnt;
        done0 = done_cnt;
        vin2 <= {code, 1'b1};
        run <= 1'b1;
        for (int i = 1; i <= 14; i++) begin
            @(posedge conv_clk);
            if (i >= 5)
                bits[14-i] = dout;
            if (i == 1) begin
                repeat (6) @(posedge clk);
                chk("oe_start", 10'h001, 10'(dout_oe));
                chk("cal_start", 10'h001, 10'(cal_en));
                if (!keep_low)
                    sc_req_n <= 1'b1;
            end
            if (i > 1 && i <= 4)
                chk("dout_low", 10'h000, 10'(dout));
            if (i == 2)
                chk("tracking", 10'h001, 10'(track_en));
            if (i == 4)
                chk("held", 10'h000, 10'({cal_en, track_en}));
            if (i == 14 && relow) begin
                repeat (2) @(posedge clk);
                sc_req_n <= 1'b0;
            end
        end
        chk("serial", code, bits);
        chk("hold_strobes", 10'h001, 10'(hold_cnt - hold0));
        chk("done_strobes", 10'h001, 10'(done_cnt - done0));
        chk("result_frame", code, result_bits);
    endtask : frame

    // Stop the clock after fall 14, then expect release of the pin
    task automatic stop_idle();
        run <= 1'b0;
        repeat (20) @(posedge clk);
        chk("oe_idle", 10'h000, 10'(dout_oe));
    endtask : stop_idle

    // Single shots at both ends of the code range and at 2a5
    task automatic t_single();
        logic [9:0] codes [3] = '{10'h000, 10'h3ff, 10'h2a5};
        foreach (codes[k]) begin
            sc_req_n <= 1'b0;
            frame(codes[k], 1'b0, 1'b0);
            stop_idle();
            chk("result", codes[k], result_bits);
            repeat (40) @(posedge clk);
            chk("still_idle", 10'h000, 10'(dout_oe));
        end
    endtask : t_single

    // Start held low: frames chain with no idle clock
    task automatic t_free();
        sc_req_n <= 1'b0;
        frame(10'h155, 1'b1, 1'b0);
        frame(10'h0ff, 1'b1, 1'b0);
        frame(10'h301, 1'b0, 1'b0);
        stop_idle();
    endtask : t_free

    // Start raised, brought low again between rise and fall of clock 14
    task automatic t_sync();
        sc_req_n <= 1'b0;
        frame(10'h0f0, 1'b0, 1'b1);
        frame(10'h30c, 1'b0, 1'b0);
        stop_idle();
    endtask : t_sync

    // Watchdog, far beyond the expected few thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        print_verdict();
    end

    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        chk("oe_reset", 10'h000, 10'(dout_oe));
        chk("result_reset", 10'h000, result_bits);
        chk("trial_reset", 10'h200, trial_code);
        t_single();
        t_free();
        t_sync();
        print_verdict();
    end
endmodule : tb_serial_sar_conversion_sequencer
